// *** hdl/iocr_pkg.sv ***
// Purpose: constants and carrier types for the I/O configuration and readback bank
// Assumes: 16-bit register port, one clock at 10 MHz
// Notes: offsets are word indices on the plain register port
package iocr_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned NPINS = 8;
	localparam int unsigned CODE_W = 12;
	// register offsets
	localparam logic [3:0] OFF_DRIVE_STYLE = 4'h0;
	localparam logic [3:0] OFF_TRISTATE = 4'h1;
	localparam logic [3:0] OFF_SOFT_RESET = 4'h2;
	localparam logic [3:0] OFF_DAC_WRITE = 4'h3;
	localparam logic [3:0] OFF_DAC_READBACK = 4'h4;
	localparam logic [3:0] OFF_ADC_WORD = 4'h5;
	localparam logic [3:0] OFF_TEMP_WORD = 4'h6;
	localparam logic [3:0] OFF_PIN_OUTPUT_CFG = 4'h7;
	localparam logic [3:0] OFF_CHANNEL_SELECT = 4'h8;
	// field values
	localparam logic [10:0] SOFT_RESET_KEY = 11'h5AC;
	localparam logic [0:0] DAC_READBACK_TAG = 1'h1;
	localparam logic [0:0] ADC_WORD_TAG = 1'h0;
	localparam logic [3:0] TEMP_TAG = 4'h8;
	localparam logic [7:0] PIN_RESET = 8'h00;
	localparam logic [11:0] CODE_RESET = 12'h000;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} iocr_bus_type;

	typedef struct packed {
		logic [7:0] drive_out;
		logic [7:0] drive_oe;
	} iocr_pins_type;
endpackage

// *** hdl/iocr_bank.sv ***
// Purpose: register bank for an eight-pin configurable I/O device
// Assumes: single clock ref_clk_i, synchronous active-high rst_i
// Notes: read data appear in the cycle after the read strobe only
// Summary of operation
// [RULE_01] drive style bits 7:0 pick open-drain (1) or push/pull (0); reset zero
// [RULE_02] drive style matters only on pins configured as digital outputs; here it still masks pin_out_o on every pin
// [RULE_03] tristate bits 7:0 float matching pin when set; reset zero
// [RULE_04] writing key 10110101100 into soft reset bits 10:0 resets whole device
// [RULE_05] DAC write stores 12-bit code into selected channel input register
// [RULE_06] DAC readback: bit15 one, channel in 14:12, code in 11:0
// [RULE_07] ADC word: bit15 zero, channel in 14:12, result in 11:0
// [RULE_08] temperature word: tag 0x8 in 15:12, result in 11:0
// [RULE_09] reserved register bits ignore writes and read zero
`timescale 1ns/1ps
`default_nettype none
module iocr_bank #(
	parameter int unsigned NPINS = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic [11:0] adc_result_i,
	input wire logic [2:0] adc_channel_i,
	input wire logic [11:0] temp_result_i,
	input wire logic [7:0] pin_level_i,
	output logic [7:0] pin_out_o,
	output logic [7:0] pin_oe_o,
	output logic soft_reset_o,
	output logic [2:0] dac_channel_o,
	output logic [11:0] dac_code_o,
	output logic dac_load_o
);
	typedef struct packed {
		logic [7:0] drive_style;
		logic [7:0] tristate;
		logic [7:0] output_cfg;
		logic [2:0] chan_sel;
		logic [7:0][11:0] dac_code;
		logic [15:0] rdata;
		logic soft_reset;
		logic dac_load;
		logic [11:0] dac_last;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
	} iocr_state_type;

	iocr_state_type state;
	iocr_state_type next_state;
	iocr_pkg::iocr_bus_type bus;
	iocr_pkg::iocr_pins_type pins;

	// pack the plain register port for decoding
	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	// place a channel and 12-bit code under a tag bit
	function automatic logic [15:0] iocr_word(input logic tag, input logic [2:0] ch,
		input logic [11:0] code);
		iocr_word = {tag, ch, code};
	endfunction

	// open-drain only pulls low; push/pull drives both levels
	function automatic iocr_pkg::iocr_pins_type iocr_drive(input logic [7:0] lvl,
		input logic [7:0] od, input logic [7:0] is_out, input logic [7:0] ts);
		iocr_drive.drive_out = lvl & ~od;
		iocr_drive.drive_oe = is_out & ~ts & (~od | ~lvl); // [RULE_01] [RULE_02] [RULE_03]
	endfunction

	// next-state logic: register writes, read mux, pin drive
	always_comb begin
		next_state = state;
		next_state.soft_reset = 1'b0;
		next_state.dac_load = 1'b0;
		next_state.rdata = iocr_pkg::UNMAPPED_READ;
		if (bus.wr) begin
			unique case (bus.addr)
				iocr_pkg::OFF_DRIVE_STYLE: begin
					next_state.drive_style = bus.wdata[7:0]; // [RULE_01] [RULE_09]
				end
				iocr_pkg::OFF_TRISTATE: begin
					next_state.tristate = bus.wdata[7:0]; // [RULE_03] [RULE_09]
				end
				iocr_pkg::OFF_SOFT_RESET: begin
					// only the exact key triggers; anything else is dropped
					next_state.soft_reset = (bus.wdata[10:0] == iocr_pkg::SOFT_RESET_KEY); // [RULE_04]
				end
				iocr_pkg::OFF_DAC_WRITE: begin
					next_state.dac_code[state.chan_sel] = bus.wdata[11:0]; // [RULE_05]
					next_state.dac_last = bus.wdata[11:0];
					next_state.dac_load = 1'b1;
				end
				iocr_pkg::OFF_PIN_OUTPUT_CFG: begin
					next_state.output_cfg = bus.wdata[7:0]; // [RULE_02]
				end
				iocr_pkg::OFF_CHANNEL_SELECT: begin
					next_state.chan_sel = bus.wdata[2:0];
				end
				default: begin
				end
			endcase
		end
		if (bus.rd) begin
			unique case (bus.addr)
				iocr_pkg::OFF_DRIVE_STYLE: next_state.rdata = {8'h00, state.drive_style}; // [RULE_09]
				iocr_pkg::OFF_TRISTATE: next_state.rdata = {8'h00, state.tristate}; // [RULE_09]
				iocr_pkg::OFF_DAC_WRITE: next_state.rdata = {4'h0, state.dac_last}; // [RULE_09]
				iocr_pkg::OFF_DAC_READBACK: next_state.rdata =
					iocr_word(iocr_pkg::DAC_READBACK_TAG, state.chan_sel,
					state.dac_code[state.chan_sel]); // [RULE_06]
				iocr_pkg::OFF_ADC_WORD: next_state.rdata =
					iocr_word(iocr_pkg::ADC_WORD_TAG, adc_channel_i, adc_result_i); // [RULE_07]
				iocr_pkg::OFF_TEMP_WORD: next_state.rdata =
					{iocr_pkg::TEMP_TAG, temp_result_i}; // [RULE_08]
				iocr_pkg::OFF_PIN_OUTPUT_CFG: next_state.rdata = {8'h00, state.output_cfg};
				iocr_pkg::OFF_CHANNEL_SELECT: next_state.rdata = {13'h0000, state.chan_sel};
				default: next_state.rdata = iocr_pkg::UNMAPPED_READ;
			endcase
		end
		pins = iocr_drive(pin_level_i, state.drive_style, state.output_cfg, state.tristate);
		next_state.pin_out = pins.drive_out;
		next_state.pin_oe = pins.drive_oe;
	end

	// a keyed reset clears the whole bank one cycle after the write, like rst_i
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || state.soft_reset) begin // [RULE_04]
			// the request bit clears too, so the keyed reset cannot latch itself on
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rdata_o = state.rdata;
	assign pin_out_o = state.pin_out;
	assign pin_oe_o = state.pin_oe;
	assign soft_reset_o = state.soft_reset;
	assign dac_channel_o = state.chan_sel;
	assign dac_code_o = state.dac_last;
	assign dac_load_o = state.dac_load;

	// checks
	logic past_valid;
	always_ff @(posedge ref_clk_i) begin
		past_valid <= !rst_i;
	end

	key_reset_fires_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_SOFT_RESET && wdata_i[10:0] == 11'h5AC
		|=> soft_reset_o ##1 (pin_oe_o == 8'h00 && dac_code_o == 12'h000))
		else $error("key write did not reset the bank"); // [RULE_04]
	wrong_key_ignored_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_SOFT_RESET && wdata_i[10:0] != 11'h5AC
		|=> !soft_reset_o)
		else $error("wrong key caused reset"); // [RULE_04]
	drive_style_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_DRIVE_STYLE ##1 rd_i && addr_i == iocr_pkg::OFF_DRIVE_STYLE
		&& !soft_reset_o |=> rdata_o == {8'h00, $past(wdata_i[7:0], 2)})
		else $error("drive style readback wrong"); // [RULE_01] [RULE_09]
	tristate_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == iocr_pkg::OFF_TRISTATE |=> rdata_o[15:8] == 8'h00)
		else $error("tristate reserved bits nonzero"); // [RULE_03] [RULE_09]
	tristate_floats_a: assert property (@(posedge ref_clk_i) disable iff (rst_i || !past_valid)
		(state.tristate & pin_oe_o) == 8'h00 || $changed(state.tristate))
		else $error("tristated pin driven"); // [RULE_03]
	output_only_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$stable(state.output_cfg) |-> (pin_oe_o & ~state.output_cfg) == 8'h00)
		else $error("non-output pin driven"); // [RULE_02]
	dac_readback_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == iocr_pkg::OFF_DAC_READBACK |=> rdata_o[15] == 1'b1
		&& rdata_o[14:12] == $past(state.chan_sel))
		else $error("dac readback format wrong"); // [RULE_06]
	dac_write_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_DAC_WRITE ##1 rd_i && addr_i == iocr_pkg::OFF_DAC_READBACK
		|=> rdata_o[11:0] == $past(wdata_i[11:0], 2))
		else $error("dac code not stored"); // [RULE_05]
	adc_word_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == iocr_pkg::OFF_ADC_WORD |=> rdata_o == {1'b0, $past(adc_channel_i),
		$past(adc_result_i)})
		else $error("adc word format wrong"); // [RULE_07]
	temp_word_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == iocr_pkg::OFF_TEMP_WORD |=> rdata_o == {4'h8, $past(temp_result_i)})
		else $error("temperature word format wrong"); // [RULE_08]
	read_one_cycle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data held too long");

	// the keyed reset request lasts one cycle only, else the bank would stay cleared
	soft_reset_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		soft_reset_o |=> !soft_reset_o)
		else $error("soft reset request stuck high"); // [RULE_04]

	// every configuration register is back at zero after the keyed reset
	soft_reset_clears_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		soft_reset_o |=> state.drive_style == 8'h00 && state.tristate == 8'h00
		&& state.output_cfg == 8'h00 && state.chan_sel == 3'h0)
		else $error("keyed reset left a register set"); // [RULE_04]

	// plain reset: read data, pin enables, reset request and load pulse read zero in the cycle after it is seen
	reset_outputs_zero_a: assert property (@(posedge ref_clk_i)
		$past(rst_i) |-> rdata_o == 16'h0000 && pin_oe_o == 8'h00
		&& soft_reset_o == 1'b0 && dac_load_o == 1'b0)
		else $error("outputs not cleared by reset"); // [RULE_01]

	// drive style write lands on the next edge, upper bits dropped
	drive_style_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_DRIVE_STYLE && !soft_reset_o
		|=> state.drive_style == $past(wdata_i[7:0]))
		else $error("drive style write lost"); // [RULE_01]

	// tristate write lands on the next edge, upper bits dropped
	tristate_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_TRISTATE && !soft_reset_o
		|=> state.tristate == $past(wdata_i[7:0]))
		else $error("tristate write lost"); // [RULE_03]

	// output configuration write lands on the next edge
	output_cfg_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_PIN_OUTPUT_CFG && !soft_reset_o
		|=> state.output_cfg == $past(wdata_i[7:0]))
		else $error("output config write lost"); // [RULE_02]

	// channel select feeds the dac channel output directly
	chan_follows_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_CHANNEL_SELECT && !soft_reset_o
		|=> dac_channel_o == $past(wdata_i[2:0]))
		else $error("channel select not applied"); // [RULE_05]

	// a dac write stores the code in the selected channel only
	dac_store_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_DAC_WRITE && !soft_reset_o
		|=> state.dac_code[$past(state.chan_sel)] == $past(wdata_i[11:0]))
		else $error("dac code not in selected channel"); // [RULE_05]

	// the load pulse carries the code that was just written
	dac_load_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_DAC_WRITE && !soft_reset_o
		|=> dac_load_o && dac_code_o == $past(wdata_i[11:0]))
		else $error("dac load pulse missing"); // [RULE_05]

	// no load pulse without a dac write one cycle earlier
	dac_load_only_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(wr_i && addr_i == iocr_pkg::OFF_DAC_WRITE) |=> !dac_load_o)
		else $error("spurious dac load pulse"); // [RULE_05]

	// reserved code bits of the dac write register read as zero
	dac_reserved_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == iocr_pkg::OFF_DAC_WRITE |=> rdata_o[15:12] == 4'h0)
		else $error("dac write reserved bits nonzero"); // [RULE_05] [RULE_09]

	// output configuration upper byte is reserved
	output_cfg_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == iocr_pkg::OFF_PIN_OUTPUT_CFG |=> rdata_o[15:8] == 8'h00)
		else $error("output config reserved bits nonzero"); // [RULE_09]

	// only three channel bits exist
	chan_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == iocr_pkg::OFF_CHANNEL_SELECT |=> rdata_o[15:3] == 13'h0000)
		else $error("channel select reserved bits nonzero"); // [RULE_09]

	// the key register is a trigger, so reading it gives nothing back
	soft_key_reads_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i == iocr_pkg::OFF_SOFT_RESET |=> rdata_o == 16'h0000)
		else $error("soft reset register reads nonzero"); // [RULE_09]

	// indices above the last register are holes in the map
	unmapped_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rd_i && addr_i > iocr_pkg::OFF_CHANNEL_SELECT |=> rdata_o == 16'h0000)
		else $error("unmapped read nonzero"); // [RULE_09]

	// pin value follows the wanted level, gated off where open drain is chosen
	pin_out_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i || !past_valid)
		!soft_reset_o |=> pin_out_o == ($past(pin_level_i) & ~$past(state.drive_style)))
		else $error("pin output level wrong"); // [RULE_01]

	// an open-drain pin may pull low but never drive high
	open_drain_high_a: assert property (@(posedge ref_clk_i) disable iff (rst_i || !past_valid)
		(pin_oe_o & pin_out_o & $past(state.drive_style)) == 8'h00)
		else $error("open-drain pin driven high"); // [RULE_01]

	soft_reset_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i) soft_reset_o);
	open_drain_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		|(state.drive_style & state.output_cfg & ~pin_oe_o));
	dac_cycle_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		dac_load_o ##[1:5] (rd_i && addr_i == iocr_pkg::OFF_DAC_READBACK));
	// a tristated output pin, the case where the float must win
	tristate_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		|(state.tristate & state.output_cfg));
	// a wrong key that must be dropped
	wrong_key_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_i && addr_i == iocr_pkg::OFF_SOFT_RESET && wdata_i[10:0] != 11'h5AC);
endmodule
`default_nettype wire

// *** testbench/iocr_bank_bench.sv ***
// Purpose: self-checking bench for the I/O configuration and readback bank
// Assumes: assertions live in the design files; the bench drives every port itself
// Notes: table rows cover plain writes and readback, hand tests cover the rest
`timescale 1ns/1ps
`default_nettype none
module iocr_bank_bench;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic [15:0] rexp;
	} iocr_row_type;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [11:0] adc_result_i = 12'h000;
	logic [2:0] adc_channel_i = 3'h0;
	logic [11:0] temp_result_i = 12'h000;
	logic [7:0] pin_level_i = 8'h00;
	logic [15:0] rdata_o;
	logic [7:0] pin_out_o;
	logic [7:0] pin_oe_o;
	logic soft_reset_o;
	logic [2:0] dac_channel_o;
	logic [11:0] dac_code_o;
	logic dac_load_o;
	int mismatches = 0;
	int checks_done = 0;
	logic [15:0] got;
	iocr_row_type rows [5];

	iocr_bank uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_result_i(adc_result_i),
		.adc_channel_i(adc_channel_i), .temp_result_i(temp_result_i),
		.pin_level_i(pin_level_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
		.soft_reset_o(soft_reset_o), .dac_channel_o(dac_channel_o),
		.dac_code_o(dac_code_o), .dac_load_o(dac_load_o));

	// 100 ns period
	initial begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one-cycle write strobe; returns at the edge that takes it
	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe, so sample just past that edge
	task rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// generous limit: the whole run is well under a thousand cycles
	initial begin
		#500000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		rows[0] = '{iocr_pkg::OFF_DRIVE_STYLE, 16'hFFA5, 16'h00A5};
		rows[1] = '{iocr_pkg::OFF_TRISTATE, 16'hFF3C, 16'h003C};
		rows[2] = '{iocr_pkg::OFF_DAC_WRITE, 16'hFABC, 16'h0ABC};
		rows[3] = '{4'hF, 16'h1234, iocr_pkg::UNMAPPED_READ};
		rows[4] = '{iocr_pkg::OFF_SOFT_RESET, 16'h05AD, 16'h0000};
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd_reg(iocr_pkg::OFF_DRIVE_STYLE, got);
		chk(got, 16'h0000);
		rd_reg(iocr_pkg::OFF_TRISTATE, got);
		chk(got, 16'h0000);
		$display("reset values done");
		for (int i = 0; i < 5; i++) begin
			wr_reg(rows[i].addr, rows[i].wdata);
			rd_reg(rows[i].addr, got);
			chk(got, rows[i].rexp);
		end
		chk({15'h0000, soft_reset_o}, 16'h0000);
		$display("table rows done");
		// channel 5 then a code with reserved bits set
		wr_reg(iocr_pkg::OFF_CHANNEL_SELECT, 16'h0005);
		wr_reg(iocr_pkg::OFF_DAC_WRITE, 16'hF123);
		chk({3'h0, dac_load_o, dac_code_o}, 16'h1123);
		chk({13'h0000, dac_channel_o}, 16'h0005);
		rd_reg(iocr_pkg::OFF_DAC_READBACK, got);
		chk(got, 16'hD123);
		@(posedge ref_clk_i);
		adc_result_i <= 12'h9E7;
		adc_channel_i <= 3'h6;
		temp_result_i <= 12'h456;
		rd_reg(iocr_pkg::OFF_ADC_WORD, got);
		chk(got, 16'h69E7);
		rd_reg(iocr_pkg::OFF_TEMP_WORD, got);
		chk(got, 16'h8456);
		$display("dac and adc words done");
		// pins 3:0 stay non-outputs, so pin_oe_o stays off there; their drive style still shows on pin_out_o
		wr_reg(iocr_pkg::OFF_PIN_OUTPUT_CFG, 16'h00F0);
		@(posedge ref_clk_i);
		pin_level_i <= 8'h99;
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk({8'h00, pin_oe_o}, 16'h0040);
		chk({8'h00, pin_out_o}, 16'h0018);
		$display("pin drive done");
		// the key pulses the reset request, then the bank clears one edge later
		wr_reg(iocr_pkg::OFF_SOFT_RESET, 16'hF5AC);
		chk({15'h0000, soft_reset_o}, 16'h0001);
		@(posedge ref_clk_i);
		#1;
		chk({15'h0000, soft_reset_o}, 16'h0000);
		chk({4'h0, dac_code_o}, 16'h0000);
		rd_reg(iocr_pkg::OFF_DRIVE_STYLE, got);
		chk(got, 16'h0000);
		chk({8'h00, pin_oe_o}, 16'h0000);
		$display("soft reset done");
		// plain reset in mid-run must clear a written register as well
		wr_reg(iocr_pkg::OFF_TRISTATE, 16'h00FF);
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd_reg(iocr_pkg::OFF_TRISTATE, got);
		chk(got, 16'h0000);
		$display("mid-run reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
